// ===== verilog/pic_pkg.sv
/*
  constants, encodings and state codes shared by both ends of the
  priority interrupt controller link.
  assumes: one clock (mclk), asynchronous active-low reset (nrst).
*/
`default_nettype none

package pic_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;   // register address width
  localparam int DATA_W = 8;   // register data width
  localparam int PC_W = 16;    // program counter width
  localparam int LEVEL_W = 4;  // request level index width
  localparam int NUM_REQS = 15;  // request levels 0..14
  localparam int LOWER_REQS = 7; // levels held in the lower pair

  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_FLAGS_UPPER = 8'hf8;
  localparam logic [7:0] OFF_MASK_UPPER = 8'hf9;
  localparam logic [7:0] OFF_FLAGS_LOWER = 8'hfa;
  localparam logic [7:0] OFF_MASK_LOWER = 8'hfb;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int GE_BIT = 7;            // global enable in lower mask
  localparam logic [7:0] FLAGS_LOWER_VALID = 8'h7f; // bit 7 reserved

  // ----------------------------------------------------------------
  // request source positions
  // ----------------------------------------------------------------
  localparam int REQ_TMR0 = 0;
  localparam int REQ_PIN4_FALL = 1;
  localparam int REQ_TMR1 = 2;
  localparam int REQ_PIN2_FALL = 3;
  localparam int REQ_PIN4_RISE = 4;
  localparam int REQ_TMR2 = 5;
  localparam int EXTRA_REQS = 9;        // levels 6..14, generic
  localparam logic [15:0] VEC_BASE = 16'h0002; // level 0 vector pair

  // ----------------------------------------------------------------
  // service sequence
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PIC_PUSH_PCL = 2'h0,
    PIC_PUSH_PCH = 2'h1,
    PIC_PUSH_FLAGS = 2'h2
  } pic_push_type;

  typedef enum logic [8:0] {
    PIC_ST_IDLE = 9'h001,
    PIC_ST_PUSHL = 9'h002,
    PIC_ST_PUSHH = 9'h004,
    PIC_ST_PUSHF = 9'h008,
    PIC_ST_CLRGE = 9'h010,
    PIC_ST_FETCHH = 9'h020,
    PIC_ST_FETCHL = 9'h040,
    PIC_ST_LOWAIT = 9'h080,
    PIC_ST_BRANCH = 9'h100
  } pic_state_type;

  // ----------------------------------------------------------------
  // core-side software registers
  // ----------------------------------------------------------------
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_PC_LO = 8'h01;
  localparam logic [7:0] HOST_PC_HI = 8'h02;
  localparam logic [7:0] HOST_FLAGS = 8'h03;
  localparam logic [7:0] HOST_SP = 8'h04;
  localparam logic [7:0] HOST_STATUS = 8'h05;
  localparam logic [7:0] HOST_VEC_ADDR = 8'h06;
  localparam logic [7:0] HOST_VEC_DATA = 8'h07;
  localparam logic [7:0] HOST_STACK_TOP = 8'h08;
  localparam int CMD_RETIRE = 0;
  localparam int CMD_EI = 1;
  localparam int CMD_DI = 2;
  localparam int CMD_SERVICE_RETURN_INSTRUCTION = 3;
  localparam logic [7:0] SP_RESET = 8'hff;
  localparam logic [15:0] PC_RESET = 16'h0000;

endpackage : pic_pkg

`default_nettype wire

// ===== verilog/pic_link_if.sv
/*
  link between the interrupt controller (dev) and the core
  instruction sequencer (core).
  assumes: both ends on mclk; every signal changes after a rising edge.
*/
`default_nettype none

interface pic_link_if;
  logic retire;        // core: instruction retires, one-cycle pulse
  logic eiCmd;         // core: global enable instruction
  logic diCmd;         // core: global disable instruction
  logic iretCmd;       // core: service return instruction
  logic regWr;         // core: register file write strobe
  logic [7:0] regAddr; // core: register address
  logic [7:0] regWdata; // core: register write data
  logic [7:0] flagsLower; // dev: request_flags_lower contents
  logic [7:0] flagsUpper; // dev: request_flags_upper contents
  logic [7:0] maskLower;  // dev: request_mask_lower contents
  logic [7:0] maskUpper;  // dev: request_mask_upper contents
  logic svcActive;     // dev: service sequence owns the core
  logic pushStrobe;    // dev: push one byte to the stack
  logic [1:0] pushSel; // dev: which byte to push
  logic fetchStrobe;   // dev: fetch program memory byte
  logic [15:0] fetchAddr; // dev: fetch address
  logic [7:0] fetchData;  // core: fetched byte, cycle after strobe
  logic branchStrobe;  // dev: branch to branchAddr
  logic [15:0] branchAddr; // dev: handler address

  modport dev (
    input retire, eiCmd, diCmd, iretCmd, regWr, regAddr, regWdata,
    input fetchData,
    output flagsLower, flagsUpper, maskLower, maskUpper, svcActive,
    output pushStrobe, pushSel, fetchStrobe, fetchAddr,
    output branchStrobe, branchAddr
  );

  modport core (
    output retire, eiCmd, diCmd, iretCmd, regWr, regAddr, regWdata,
    output fetchData,
    input flagsLower, flagsUpper, maskLower, maskUpper, svcActive,
    input pushStrobe, pushSel, fetchStrobe, fetchAddr,
    input branchStrobe, branchAddr
  );
endinterface : pic_link_if

`default_nettype wire

// ===== verilog/pic_edge_detect.sv
/*
  pin synchroniser with rise and fall pulse outputs.
  assumes: pin is asynchronous to mclk and held long enough low and
  high to be seen by two samples.
*/
`default_nettype none

module pic_edge_detect #(
  parameter logic IDLE_LEVEL = 1'b1 // level the pin rests at
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sync1; // first stage, read only by sync2
    logic sync2; // second stage
    logic last;  // previous synchronised level
    logic rise;
    logic fall;
  } pic_edge_state_type;

  pic_edge_state_type s_r;
  pic_edge_state_type s_nxt;

  // edges compare the two settled stages only
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = pin;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.last = s_r.sync2;
    s_nxt.rise = s_r.sync2 & ~s_r.last;
    s_nxt.fall = ~s_r.sync2 & s_r.last;
  end

  // reset to idle level so no false edge follows reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL, 1'b0, 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rise = s_r.rise;
  assign fall = s_r.fall;

endmodule : pic_edge_detect

`default_nettype wire

// ===== verilog/pic_controller.sv
/*
  interrupt controller end: request latches, masks, fixed priority
  and the service sequence that drives the core.
  assumes: core keeps retire low while svcActive is high and answers
  each fetch strobe with data in the next cycle.
*/
// Notes on behaviour
// - fifteen request levels, pins, peripherals, software
// - mask lower bit 7 is global enable
// - check at retire, then service instead
// - lowest-numbered eligible request wins
// - push, clear request and enable, fetch, branch
// - pcl, pch, flags, clear enable, vector hi, lo
// - level n vector pair at two plus 2n
// - pin edges set requests one, three, four
// - timer time-outs set requests zero, two, five
// - lower mask bits 0..6 enable levels 0..6
// - upper mask bits enable levels 7..14
// - enable clears on entry, sets on return
// - both masks reset to zero
// - lower flags hold levels 0..6, reset zero
// - upper flags hold levels 7..14
// - software-written requests serviced like hardware
// - software write beats same-cycle hardware set
// - masked requests latch and stay readable
// - nesting handled by software saving masks
// - software changes enable by instructions or by a lower mask write
`default_nettype none

module pic_controller #(
  parameter int EXTRA = pic_pkg::EXTRA_REQS // generic levels 6..14
) (
  input wire logic mclk,
  input wire logic nrst,
  pic_link_if.dev link,
  input wire logic tmr0Timeout, // same-clock pulse
  input wire logic tmr1Timeout,
  input wire logic tmr2Timeout,
  input wire logic portPinFour, // asynchronous pin
  input wire logic portPinTwo,  // asynchronous pin
  input wire logic [EXTRA-1:0] extraReq, // levels 6.., same clock
  output logic globalEnable,
  output logic [pic_pkg::LEVEL_W-1:0] serviceLevel
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pic_pkg::pic_state_type st;
    logic [7:0] flagsLower; // levels 0..6, bit 7 reads 0
    logic [7:0] flagsUpper; // levels 7..14
    logic [7:0] maskLower;  // bit 7 global enable
    logic [7:0] maskUpper;
    logic [pic_pkg::LEVEL_W-1:0] level; // level in service
    logic [7:0] vecHi;      // captured vector high byte
    logic pushStrobe;
    logic [1:0] pushSel;
    logic fetchStrobe;
    logic [15:0] fetchAddr;
    logic branchStrobe;
    logic [15:0] branchAddr;
    logic svcActive;
  } pic_ctl_state_type;

  pic_ctl_state_type s_r;
  pic_ctl_state_type s_nxt;

  // ----------------------------------------------------------------
  // pin edge detection
  // ----------------------------------------------------------------
  logic pin4Rise; // port pin four low-to-high
  logic pin4Fall; // port pin four high-to-low
  logic pin2Fall; // port pin two high-to-low

  pic_edge_detect #(.IDLE_LEVEL(1'b1)) u_pin4 (
    .mclk(mclk),
    .nrst(nrst),
    .pin(portPinFour),
    .rise(pin4Rise),
    .fall(pin4Fall)
  );

  pic_edge_detect #(.IDLE_LEVEL(1'b1)) u_pin2 (
    .mclk(mclk),
    .nrst(nrst),
    .pin(portPinTwo),
    .rise(),
    .fall(pin2Fall)
  );

  // ----------------------------------------------------------------
  // request sources, eligibility and priority
  // ----------------------------------------------------------------
  logic [14:0] hwSet;    // hardware set pulses by level
  logic [14:0] eligible; // flag, mask and enable all true
  logic [14:0] clrVec;   // serviced level to clear
  logic found;           // some request is eligible
  logic [pic_pkg::LEVEL_W-1:0] winner;
  logic [15:0] vecAddr;  // vector pair base of level in service

  always_comb begin
    hwSet = '0;
    hwSet[pic_pkg::REQ_TMR0] = tmr0Timeout;
    hwSet[pic_pkg::REQ_TMR1] = tmr1Timeout;
    hwSet[pic_pkg::REQ_TMR2] = tmr2Timeout;
    hwSet[pic_pkg::REQ_PIN4_FALL] = pin4Fall;
    hwSet[pic_pkg::REQ_PIN2_FALL] = pin2Fall;
    hwSet[pic_pkg::REQ_PIN4_RISE] = pin4Rise;
    hwSet[14:6] = extraReq;
  end

  // masked bits still sit in the flags, so polling sees them
  assign eligible = {s_r.flagsUpper, s_r.flagsLower[6:0]}
    & {s_r.maskUpper, s_r.maskLower[6:0]}
    & {15{s_r.maskLower[pic_pkg::GE_BIT]}};

  // scan downward so the lowest index is kept last
  always_comb begin
    found = 1'b0;
    winner = '0;
    for (int i = pic_pkg::NUM_REQS - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        found = 1'b1;
        winner = pic_pkg::LEVEL_W'(i);
      end
    end
  end

  assign clrVec = 15'h0001 << s_r.level;
  assign vecAddr = pic_pkg::VEC_BASE + 16'({s_r.level, 1'b0});

  // ----------------------------------------------------------------
  // next state: registers and service sequence
  // ----------------------------------------------------------------
  always_comb begin
    logic inClr; // clear step of the sequence
    inClr = (s_r.st == pic_pkg::PIC_ST_CLRGE);
    s_nxt = s_r;
    s_nxt.pushStrobe = 1'b0;
    s_nxt.fetchStrobe = 1'b0;
    s_nxt.branchStrobe = 1'b0;

    // request latches: a same-cycle hardware set beats the clear
    s_nxt.flagsLower = (s_r.flagsLower
      & ~({1'b0, clrVec[6:0]} & {8{inClr}}))
      | ({1'b0, hwSet[6:0]});
    s_nxt.flagsUpper = (s_r.flagsUpper & ~(clrVec[14:7] & {8{inClr}}))
      | hwSet[14:7];

    // global enable by instruction, cleared on entry
    if (link.eiCmd || link.iretCmd) begin
      s_nxt.maskLower[pic_pkg::GE_BIT] = 1'b1;
    end
    if (link.diCmd || inClr) begin
      s_nxt.maskLower[pic_pkg::GE_BIT] = 1'b0;
    end

    // software write last: it overrides hardware sets
    if (link.regWr) begin
      case (link.regAddr)
        pic_pkg::OFF_FLAGS_LOWER: begin
          s_nxt.flagsLower = link.regWdata
            & pic_pkg::FLAGS_LOWER_VALID;
        end
        pic_pkg::OFF_FLAGS_UPPER: begin
          s_nxt.flagsUpper = link.regWdata;
        end
        pic_pkg::OFF_MASK_LOWER: begin
          s_nxt.maskLower = link.regWdata;
        end
        pic_pkg::OFF_MASK_UPPER: begin
          s_nxt.maskUpper = link.regWdata;
        end
        default: begin
          // other addresses belong to the rest of the register file
        end
      endcase
    end

    // service sequence, one step per cycle
    case (s_r.st)
      pic_pkg::PIC_ST_IDLE: begin
        if (link.retire && found) begin
          s_nxt.level = winner;
          s_nxt.st = pic_pkg::PIC_ST_PUSHL;
          s_nxt.svcActive = 1'b1;
          s_nxt.pushStrobe = 1'b1;
          s_nxt.pushSel = pic_pkg::PIC_PUSH_PCL;
        end
      end
      pic_pkg::PIC_ST_PUSHL: begin
        s_nxt.st = pic_pkg::PIC_ST_PUSHH;
        s_nxt.pushStrobe = 1'b1;
        s_nxt.pushSel = pic_pkg::PIC_PUSH_PCH;
      end
      pic_pkg::PIC_ST_PUSHH: begin
        s_nxt.st = pic_pkg::PIC_ST_PUSHF;
        s_nxt.pushStrobe = 1'b1;
        s_nxt.pushSel = pic_pkg::PIC_PUSH_FLAGS;
      end
      pic_pkg::PIC_ST_PUSHF: begin
        s_nxt.st = pic_pkg::PIC_ST_CLRGE;
      end
      pic_pkg::PIC_ST_CLRGE: begin
        s_nxt.st = pic_pkg::PIC_ST_FETCHH;
        s_nxt.fetchStrobe = 1'b1;
        s_nxt.fetchAddr = vecAddr;
      end
      pic_pkg::PIC_ST_FETCHH: begin
        s_nxt.st = pic_pkg::PIC_ST_FETCHL;
        s_nxt.fetchStrobe = 1'b1;
        s_nxt.fetchAddr = vecAddr + 16'h0001;
      end
      pic_pkg::PIC_ST_FETCHL: begin
        s_nxt.st = pic_pkg::PIC_ST_LOWAIT;
        s_nxt.vecHi = link.fetchData; // high byte arrives now
      end
      pic_pkg::PIC_ST_LOWAIT: begin
        s_nxt.st = pic_pkg::PIC_ST_BRANCH;
        s_nxt.branchStrobe = 1'b1;
        s_nxt.branchAddr = {s_r.vecHi, link.fetchData};
      end
      pic_pkg::PIC_ST_BRANCH: begin
        s_nxt.st = pic_pkg::PIC_ST_IDLE;
        s_nxt.svcActive = 1'b0;
      end
      default: begin
        // unreachable code, recover to idle
        s_nxt.st = pic_pkg::PIC_ST_IDLE;
        s_nxt.svcActive = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.st <= pic_pkg::PIC_ST_IDLE;
      s_r.flagsLower <= pic_pkg::RESET_BYTE;
      s_r.flagsUpper <= pic_pkg::RESET_BYTE;
      s_r.maskLower <= pic_pkg::RESET_BYTE;
      s_r.maskUpper <= pic_pkg::RESET_BYTE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign link.flagsLower = s_r.flagsLower;
  assign link.flagsUpper = s_r.flagsUpper;
  assign link.maskLower = s_r.maskLower;
  assign link.maskUpper = s_r.maskUpper;
  assign link.svcActive = s_r.svcActive;
  assign link.pushStrobe = s_r.pushStrobe;
  assign link.pushSel = s_r.pushSel;
  assign link.fetchStrobe = s_r.fetchStrobe;
  assign link.fetchAddr = s_r.fetchAddr;
  assign link.branchStrobe = s_r.branchStrobe;
  assign link.branchAddr = s_r.branchAddr;
  assign globalEnable = s_r.maskLower[pic_pkg::GE_BIT];
  assign serviceLevel = s_r.level;

endmodule : pic_controller

`default_nettype wire

// ===== verilog/pic_core_end.sv
/*
  core sequencer end: turns software commands into retire and
  enable instructions, holds the stack and vector memory and follows
  the controller's service sequence.
  assumes: software drives a plain strobe port on mclk.
*/
`default_nettype none

module pic_core_end #(
  parameter int STACK_DEPTH = 16, // stack bytes
  parameter int VEC_DEPTH = 32    // vector memory bytes
) (
  input wire logic mclk,
  input wire logic nrst,
  pic_link_if.core link,
  input wire logic [7:0] swAddr,
  input wire logic [7:0] swWdata,
  input wire logic swWr,
  input wire logic swRd,
  output logic [7:0] swRdata,
  output logic coreBusy
);

  localparam int SA_W = $clog2(STACK_DEPTH);
  localparam int VA_W = $clog2(VEC_DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic retire;
    logic eiCmd;
    logic diCmd;
    logic iretCmd;
    logic regWr;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] fetchData;
    logic [15:0] pc;
    logic [7:0] flags;
    logic [7:0] sp;      // next free stack byte, grows down
    logic [7:0] vecAddr; // vector memory write pointer
    logic [7:0] rdata;
    logic busy;
  } pic_core_state_type;

  pic_core_state_type s_r;
  pic_core_state_type s_nxt;
  logic [7:0] vecMem [VEC_DEPTH];  // program memory vectors
  logic [7:0] stack [STACK_DEPTH]; // pushed bytes
  logic [7:0] pushByte;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.retire = 1'b0;
    s_nxt.eiCmd = 1'b0;
    s_nxt.diCmd = 1'b0;
    s_nxt.iretCmd = 1'b0;
    s_nxt.regWr = 1'b0;
    s_nxt.rdata = '0;
    s_nxt.busy = link.svcActive;

    // software port; instructions are refused during service
    if (swWr) begin
      case (swAddr)
        pic_pkg::HOST_CMD: begin
          if (!link.svcActive) begin
            s_nxt.retire = swWdata[pic_pkg::CMD_RETIRE];
            s_nxt.eiCmd = swWdata[pic_pkg::CMD_EI];
            s_nxt.diCmd = swWdata[pic_pkg::CMD_DI];
            s_nxt.iretCmd = swWdata[pic_pkg::CMD_SERVICE_RETURN_INSTRUCTION];
          end
        end
        pic_pkg::HOST_PC_LO: s_nxt.pc[7:0] = swWdata;
        pic_pkg::HOST_PC_HI: s_nxt.pc[15:8] = swWdata;
        pic_pkg::HOST_FLAGS: s_nxt.flags = swWdata;
        pic_pkg::HOST_SP: s_nxt.sp = swWdata;
        pic_pkg::HOST_VEC_ADDR: s_nxt.vecAddr = swWdata;
        pic_pkg::HOST_VEC_DATA: begin
          s_nxt.vecAddr = s_r.vecAddr + 8'h01; // auto-increment
        end
        pic_pkg::OFF_FLAGS_LOWER, pic_pkg::OFF_FLAGS_UPPER,
        pic_pkg::OFF_MASK_LOWER, pic_pkg::OFF_MASK_UPPER: begin
          s_nxt.regWr = 1'b1;
          s_nxt.regAddr = swAddr;
          s_nxt.regWdata = swWdata;
        end
        default: begin
          // unmapped: ignored
        end
      endcase
    end

    // service sequence steps from the controller
    if (link.fetchStrobe) begin
      s_nxt.fetchData = vecMem[link.fetchAddr[VA_W-1:0]];
    end
    if (link.pushStrobe) begin
      s_nxt.sp = s_r.sp - 8'h01;
    end
    if (link.branchStrobe) begin
      s_nxt.pc = link.branchAddr; // branch beats software pc write
    end

    // read data stands only in the cycle after the strobe
    if (swRd) begin
      case (swAddr)
        pic_pkg::HOST_PC_LO: s_nxt.rdata = s_r.pc[7:0];
        pic_pkg::HOST_PC_HI: s_nxt.rdata = s_r.pc[15:8];
        pic_pkg::HOST_FLAGS: s_nxt.rdata = s_r.flags;
        pic_pkg::HOST_SP: s_nxt.rdata = s_r.sp;
        pic_pkg::HOST_STATUS: s_nxt.rdata = {7'h00, link.svcActive};
        pic_pkg::HOST_VEC_ADDR: s_nxt.rdata = s_r.vecAddr;
        pic_pkg::HOST_STACK_TOP: begin
          s_nxt.rdata = stack[SA_W'(s_r.sp + 8'h01)];
        end
        pic_pkg::OFF_FLAGS_LOWER: s_nxt.rdata = link.flagsLower;
        pic_pkg::OFF_FLAGS_UPPER: s_nxt.rdata = link.flagsUpper;
        pic_pkg::OFF_MASK_LOWER: s_nxt.rdata = link.maskLower;
        pic_pkg::OFF_MASK_UPPER: s_nxt.rdata = link.maskUpper;
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  // byte the controller asks to push
  always_comb begin
    case (link.pushSel)
      pic_pkg::PIC_PUSH_PCL: pushByte = s_r.pc[7:0];
      pic_pkg::PIC_PUSH_PCH: pushByte = s_r.pc[15:8];
      default: pushByte = s_r.flags;
    endcase
  end

  // ----------------------------------------------------------------
  // registers and memories
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.pc <= pic_pkg::PC_RESET;
      s_r.sp <= pic_pkg::SP_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // memories carry no reset; software loads the vector table
  always_ff @(posedge mclk) begin
    if (swWr && swAddr == pic_pkg::HOST_VEC_DATA) begin
      vecMem[s_r.vecAddr[VA_W-1:0]] <= swWdata;
    end
    if (link.pushStrobe) begin
      stack[s_r.sp[SA_W-1:0]] <= pushByte;
    end
  end

  assign link.retire = s_r.retire;
  assign link.eiCmd = s_r.eiCmd;
  assign link.diCmd = s_r.diCmd;
  assign link.iretCmd = s_r.iretCmd;
  assign link.regWr = s_r.regWr;
  assign link.regAddr = s_r.regAddr;
  assign link.regWdata = s_r.regWdata;
  assign link.fetchData = s_r.fetchData;
  assign swRdata = s_r.rdata;
  assign coreBusy = s_r.busy;

endmodule : pic_core_end

`default_nettype wire

// ===== dv/pic_properties.sv
/* checker: service sequence timing seen on the link.
   assumes: instantiated beside the link, one clock mclk. */
`default_nettype none
module pic_properties (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic retire,
  input wire logic [7:0] flagsLower,
  input wire logic [7:0] maskLower,
  input wire logic svcActive,
  input wire logic pushStrobe,
  input wire logic [1:0] pushSel,
  input wire logic fetchStrobe,
  input wire logic [15:0] fetchAddr,
  input wire logic branchStrobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // vector pair of the lowest set level, two plus twice the level
  function automatic logic [15:0] vecOf(input logic [6:0] e);
    vecOf = 16'h0000;
    for (int i = 6; i >= 0; i--) if (e[i]) vecOf = 16'(2 + 2 * i);
  endfunction : vecOf
  // eligible lower levels held from the retire that started a service
  logic [6:0] eligR;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) eligR <= 7'h00;
    else if (retire) eligR <= flagsLower[6:0] & maskLower[6:0];
  a_service_start: assert property (retire && !svcActive &&
    maskLower[7] && (flagsLower[6:0] & maskLower[6:0]) != 7'h00
    |=> svcActive) else $error("no service after eligible retire");
  a_no_service: assert property (retire && !svcActive &&
    !maskLower[7] |=> !svcActive) else $error("service while disabled");
  a_push_order: assert property ($rose(svcActive) |->
    pushStrobe && pushSel == 2'h0 ##1 pushStrobe && pushSel == 2'h1
    ##1 pushStrobe && pushSel == 2'h2) else $error("push order wrong");
  a_enable_cleared: assert property ($rose(svcActive) |->
    ##4 !maskLower[7]) else $error("enable not cleared on entry");
  a_fetch_pair: assert property ($rose(svcActive) |-> ##4
    fetchStrobe ##1 fetchStrobe && fetchAddr == $past(fetchAddr) + 1)
    else $error("vector bytes not fetched as a pair");
  a_level_vector: assert property (retire && !svcActive &&
    maskLower[7] && (flagsLower[6:0] & maskLower[6:0]) != 7'h00
    |-> ##5 fetchAddr == vecOf(eligR)) else $error("wrong vector");
  a_branch_time: assert property ($rose(svcActive) |->
    ##7 branchStrobe ##1 !svcActive) else $error("branch misplaced");
  a_push_inside: assert property (pushStrobe |-> svcActive)
    else $error("push outside service");
endmodule : pic_properties
`default_nettype wire

// ===== dv/priority_interrupt_controller_tb.sv
/* bench: both link ends joined, driven over the software port.
   assumes: package, link and design modules compiled first. */
`default_nettype none
module priority_interrupt_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, nrst, swWr, swRd, tmr0, tmr1, tmr2, pin4, pin2;
  logic [7:0] swAddr, swWdata, swRdata;
  logic [8:0] extraReq; // generic levels 6..14
  logic [15:0] brAddr; // last branch target seen on the link
  logic [3:0] svcLevel; // level last taken into service
  logic globalEn, coreBusy; // controller and core status outputs
  int failures, checked;
  pic_link_if link ();
  pic_controller pic_controller_inst (.mclk, .nrst, .link(link),
    .tmr0Timeout(tmr0), .tmr1Timeout(tmr1), .tmr2Timeout(tmr2),
    .portPinFour(pin4), .portPinTwo(pin2), .extraReq,
    .globalEnable(globalEn), .serviceLevel(svcLevel));
  pic_core_end pic_core_end_inst (.mclk, .nrst, .link(link), .swAddr,
    .swWdata, .swWr, .swRd, .swRdata, .coreBusy);
  pic_properties pic_properties_inst (.mclk, .nrst,
    .retire(link.retire), .flagsLower(link.flagsLower),
    .maskLower(link.maskLower), .svcActive(link.svcActive),
    .pushStrobe(link.pushStrobe), .pushSel(link.pushSel),
    .fetchStrobe(link.fetchStrobe), .fetchAddr(link.fetchAddr),
    .branchStrobe(link.branchStrobe));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) if (link.branchStrobe === 1'b1)
    brAddr <= link.branchAddr;
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    {swAddr, swWdata, swWr} <= {a, d, 1'b1};
    @(posedge mclk);
    swWr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    {swAddr, swRd} <= {a, 1'b1};
    @(posedge mclk);
    swRd <= 1'b0;
    @(negedge mclk);
    cmp({8'h00, swRdata}, {8'h00, exp});
  endtask : rd
  task t_reset();
    for (int a = 8'hf8; a <= 8'hfb; a++) rd(8'(a), 8'h00);
    rd(8'h40, 8'h00);
    wr(8'hf9, 8'h5a);
    rd(8'hf9, 8'h5a);
  endtask : t_reset
  // masked sources still latch; software clears them by writing
  task t_poll();
    @(posedge mclk);
    {tmr0, tmr1, tmr2, extraReq, pin4, pin2} <= {3'h7, 9'h002, 2'h0};
    @(posedge mclk);
    {tmr0, tmr1, tmr2, extraReq} <= 12'h000;
    repeat (7) @(posedge mclk);
    pin4 <= 1'b1;
    repeat (7) @(posedge mclk);
    rd(8'hfa, 8'h3f);
    rd(8'hf8, 8'h01);
    wr(8'hfa, 8'h00);
    wr(8'hf8, 8'h00);
    rd(8'hfa, 8'h00);
  endtask : t_poll
  // timer set lands in the same cycle as the software write
  task t_override();
    wr(8'hfa, 8'h00);
    tmr1 <= 1'b1;
    @(posedge mclk);
    tmr1 <= 1'b0;
    rd(8'hfa, 8'h00);
  endtask : t_override
  task t_service();
    wr(8'h06, 8'h00);
    for (int a = 0; a < 16; a++) wr(8'h07, 8'(a + 8'h40));
    wr(8'hfa, 8'h24);
    wr(8'hfb, 8'h24);
    wr(8'h03, 8'h5c); // flags byte the service must push last
    wr(8'h00, 8'h02);
    wr(8'h00, 8'h04);
    wr(8'h00, 8'h01);
    repeat (14) @(posedge mclk);
    rd(8'hfa, 8'h24);
    wr(8'h00, 8'h02);
    wr(8'h00, 8'h01);
    repeat (14) @(posedge mclk);
    cmp(brAddr, 16'h4647);
    cmp({12'h000, svcLevel}, 16'h0002);
    cmp({15'h0000, globalEn}, 16'h0000);
    rd(8'h08, 8'h5c);
    rd(8'h04, 8'hfc);
    rd(8'h05, 8'h00);
    rd(8'hfa, 8'h20);
    rd(8'hfb, 8'h24);
    wr(8'h00, 8'h08);
    rd(8'hfb, 8'ha4);
    cmp({15'h0000, globalEn}, 16'h0001);
    wr(8'h00, 8'h01);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    cmp({15'h0000, coreBusy}, 16'h0001);
    repeat (11) @(posedge mclk);
    cmp(brAddr, 16'h4c4d);
    cmp({12'h000, svcLevel}, 16'h0005);
    rd(8'hfa, 8'h00);
    cmp({15'h0000, coreBusy}, 16'h0000);
  endtask : t_service
  task test_done();
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial begin
    {nrst, swWr, swRd, tmr0, tmr1, tmr2, extraReq} = '0;
    {pin4, pin2, swAddr, swWdata, brAddr} = {2'h3, 32'h0};
    {failures, checked} = '0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_poll();
    t_override();
    t_service();
    test_done();
  end
  // watchdog: the sequence needs well under ten microseconds
  initial begin
    #50us;
    failures++;
    test_done();
  end
endmodule : priority_interrupt_controller_tb
`default_nettype wire
